// [hdl/smf_fifo2.sv]
// smf_fifo2: small register-array fifo with valid/ready on both sides.
// assumes push and pop come from logic on the same clock.
`timescale 1ns/100ps

module smf_fifo2 #(
    parameter  int W     = 8,
    parameter  int DEPTH = 2,
    localparam int PW    = (DEPTH > 1) ? $clog2(DEPTH) : 1,
    localparam int CW    = $clog2(DEPTH + 1)
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    // fill side
    input  wire logic          in_valid_i,
    output logic               in_ready_o,
    input  wire logic [W-1:0]  in_data_i,
    // drain side
    output logic               out_valid_o,
    input  wire logic          out_ready_i,
    output logic [W-1:0]       out_data_o,
    // fill level
    output logic [CW-1:0]      level_o
);

    logic [W-1:0]  mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [CW-1:0] cnt_ff;
    logic          push;
    logic          pop;

    // pointer wrap for depths that are not a power of two
    function automatic logic [PW-1:0] nxt_ptr(input logic [PW-1:0] p);
        nxt_ptr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : nxt_ptr

    // honest flags straight from the count
    assign in_ready_o  = (cnt_ff != CW'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem_ff[rd_ptr_ff];
    assign level_o     = cnt_ff;

    // storage, no reset needed on the data itself
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    // pointers and count
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= nxt_ptr(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= nxt_ptr(rd_ptr_ff);
            end
            if (push && !pop) begin
                cnt_ff <= CW'(cnt_ff + 1'b1);
            end else if (pop && !push) begin
                cnt_ff <= CW'(cnt_ff - 1'b1);
            end
        end
    end

endmodule : smf_fifo2

// [hdl/smf_pkg.sv]
// smf_pkg: constants, register map and carrier types of the spi master with two-byte fifos.
// assumes one mcu clock at 250 MHz and a byte-wide special-function-register bus.

package smf_pkg;

    // ----------------------------------------------------------------
    // register addresses and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] SMF_ADDR_CFG   = 8'hfc;
    localparam logic [7:0] SMF_ADDR_MASK  = 8'hfd;
    localparam logic [7:0] SMF_ADDR_FLAGS = 8'hfe;
    localparam logic [7:0] SMF_ADDR_DATA  = 8'hff;
    localparam logic [7:0] SMF_CFG_RST    = 8'h20;
    localparam logic [7:0] SMF_MASK_RST   = 8'h0f;
    localparam logic [7:0] SMF_DATA_RST   = 8'h00;

    // ----------------------------------------------------------------
    // serial timing
    // ----------------------------------------------------------------
    localparam int          SMF_CPU_CLK_FREQ_MHZ = 250;   // cpu_clk_freq
    localparam int          SMF_DATA_W           = 8;
    localparam int          SMF_FIFO_DEPTH       = 2;
    localparam logic [3:0]  SMF_LAST_EDGE        = 4'hf;  // 16 edges per byte
    // half period of the serial clock, minus one, in mcu clocks
    localparam logic [4:0]  SMF_HALF_DIV2        = 5'h00;
    localparam logic [4:0]  SMF_HALF_DIV4        = 5'h01;
    localparam logic [4:0]  SMF_HALF_DIV8        = 5'h03;
    localparam logic [4:0]  SMF_HALF_DIV16       = 5'h07;
    localparam logic [4:0]  SMF_HALF_DIV32       = 5'h0f;
    localparam logic [4:0]  SMF_HALF_DIV64       = 5'h1f;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       rsvd;
        logic [2:0] sck_divider_sel;
        logic       bit_order_sel;
        logic       sck_idle_level;
        logic       sample_edge_sel;
        logic       master_on;
    } smf_cfg_t;

    typedef struct packed {
        logic [3:0] rsvd;
        logic       mask_rx_full;
        logic       mask_rx_avail;
        logic       mask_tx_empty;
        logic       mask_tx_space;
    } smf_mask_t;

    typedef struct packed {
        logic [3:0] rsvd;
        logic       rx_full_flag;
        logic       rx_avail_flag;
        logic       tx_empty_flag;
        logic       tx_space_flag;
    } smf_flags_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } smf_sfr_req_t;

    typedef enum logic [0:0] {
        SMF_IDLE  = 1'b0,
        SMF_SHIFT = 1'b1
    } smf_state_t;

endpackage : smf_pkg

// [hdl/smf_spi_master.sv]
// smf_spi_master: spi master core with register file on the sfr bus and two-byte fifos.
// assumes a single mcu clock; slave selects come from general-purpose pins elsewhere.
`timescale 1ns/100ps

module smf_spi_master (
    // clock and reset
    input  wire logic                  CLK_I,
    input  wire logic                  RST_B_I,
    // sfr bus
    input  wire smf_pkg::smf_sfr_req_t SFR_REQ_I,
    output logic [7:0]                 SFR_RDATA_O,
    // serial pins
    output logic                       SER_CLK_OUT_O,
    output logic                       SER_DATA_OUT_O,
    input  wire logic                  SER_DATA_IN_I,
    // interrupt
    output logic                       IRQ_O
);
    import smf_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    smf_cfg_t                  cfg_ff;
    smf_mask_t                 mask_ff;
    smf_flags_t                flags;
    smf_state_t                state_ff;
    logic [7:0]                rdata_ff;
    logic                      irq_ff;
    logic                      din_s1_ff;
    logic                      din_s2_ff;
    logic [4:0]                div_cnt_ff;
    logic [4:0]                half_m1;
    logic [3:0]                edge_idx_ff;
    logic                      sck_ff;
    logic                      mosi_ff;
    logic [SMF_DATA_W-1:0]     tx_sh_ff;
    logic [SMF_DATA_W-1:0]     rx_sh_ff;
    logic [SMF_DATA_W-1:0]     nxt_rx_sh;
    logic                      wr_cfg;
    logic                      wr_mask;
    logic                      wr_data;
    logic                      rd_data;
    logic                      tick;
    logic                      start;
    logic                      done;
    logic                      lead;
    logic                      shift_evt;
    logic                      sample_evt;
    logic                      tx_in_ready;
    logic                      tx_out_valid;
    logic [SMF_DATA_W-1:0]     tx_out_data;
    logic [1:0]                tx_level;
    logic                      rx_in_ready;
    logic                      rx_out_valid;
    logic [SMF_DATA_W-1:0]     rx_out_data;
    logic [1:0]                rx_level;

    // bit selected first on the line for the chosen order
    function automatic logic first_bit(input logic [SMF_DATA_W-1:0] v, input logic lsb);
        first_bit = lsb ? v[0] : v[SMF_DATA_W-1];
    endfunction : first_bit

    function automatic logic [SMF_DATA_W-1:0] shift_out(input logic [SMF_DATA_W-1:0] v, input logic lsb);
        shift_out = lsb ? {1'b0, v[SMF_DATA_W-1:1]} : {v[SMF_DATA_W-2:0], 1'b0};
    endfunction : shift_out

    // ----------------------------------------------------------------
    // sfr decode and registers
    // ----------------------------------------------------------------
    assign wr_cfg  = SFR_REQ_I.wr && (SFR_REQ_I.addr == SMF_ADDR_CFG);
    assign wr_mask = SFR_REQ_I.wr && (SFR_REQ_I.addr == SMF_ADDR_MASK);
    assign wr_data = SFR_REQ_I.wr && (SFR_REQ_I.addr == SMF_ADDR_DATA);
    assign rd_data = SFR_REQ_I.rd && (SFR_REQ_I.addr == SMF_ADDR_DATA);

    // config and mask; reserved bits are kept at zero
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            cfg_ff  <= smf_cfg_t'(SMF_CFG_RST);
            mask_ff <= smf_mask_t'(SMF_MASK_RST);
        end else begin
            if (wr_cfg) begin
                cfg_ff      <= smf_cfg_t'(SFR_REQ_I.wdata);
                cfg_ff.rsvd <= 1'b0;
            end
            if (wr_mask) begin
                mask_ff      <= smf_mask_t'(SFR_REQ_I.wdata);
                mask_ff.rsvd <= '0;
            end
        end
    end

    // status follows the fifos live, nothing to clear by software
    always_comb begin
        flags               = '0;
        flags.rx_full_flag  = !rx_in_ready;
        flags.rx_avail_flag = rx_out_valid;
        flags.tx_empty_flag = (tx_level == '0);
        flags.tx_space_flag = tx_in_ready;
    end

    // read data registered; a read of an empty rx fifo returns zero
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            rdata_ff <= SMF_DATA_RST;
        end else if (SFR_REQ_I.rd) begin
            case (SFR_REQ_I.addr)
                SMF_ADDR_CFG:   rdata_ff <= cfg_ff;
                SMF_ADDR_MASK:  rdata_ff <= mask_ff;
                SMF_ADDR_FLAGS: rdata_ff <= flags;
                SMF_ADDR_DATA:  rdata_ff <= rx_out_valid ? rx_out_data : SMF_DATA_RST;
                default:        rdata_ff <= SMF_DATA_RST;
            endcase
        end
    end
    assign SFR_RDATA_O = rdata_ff;

    // masked sources onto one interrupt line
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(flags[3:0] & ~mask_ff[3:0]);
        end
    end
    assign IRQ_O = irq_ff;

    // ----------------------------------------------------------------
    // fifos: tx filled by sfr writes, rx drained by sfr reads
    // ----------------------------------------------------------------
    // a write to a full tx fifo is dropped, software must watch the space flag
    smf_fifo2 #(.W(SMF_DATA_W), .DEPTH(SMF_FIFO_DEPTH)) u_tx_fifo (
        .clk_i       (CLK_I),
        .rst_b_i     (RST_B_I),
        .in_valid_i  (wr_data),
        .in_ready_o  (tx_in_ready),
        .in_data_i   (SFR_REQ_I.wdata),
        .out_valid_o (tx_out_valid),
        .out_ready_i (start),
        .out_data_o  (tx_out_data),
        .level_o     (tx_level)
    );

    smf_fifo2 #(.W(SMF_DATA_W), .DEPTH(SMF_FIFO_DEPTH)) u_rx_fifo (
        .clk_i       (CLK_I),
        .rst_b_i     (RST_B_I),
        .in_valid_i  (done),
        .in_ready_o  (rx_in_ready),
        .in_data_i   (nxt_rx_sh),
        .out_valid_o (rx_out_valid),
        .out_ready_i (rd_data),
        .out_data_o  (rx_out_data),
        .level_o     (rx_level)
    );

    // ----------------------------------------------------------------
    // serial engine
    // ----------------------------------------------------------------
    // input synchroniser; adds two clocks, so the fastest divisions
    // only work with a slave that answers well inside a half period
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            din_s1_ff <= 1'b0;
            din_s2_ff <= 1'b0;
        end else begin
            din_s1_ff <= SER_DATA_IN_I;
            din_s2_ff <= din_s1_ff;
        end
    end

    // half-period length from the divider code
    always_comb begin
        case (cfg_ff.sck_divider_sel)
            3'h0:    half_m1 = SMF_HALF_DIV2;
            3'h1:    half_m1 = SMF_HALF_DIV4;
            3'h2:    half_m1 = SMF_HALF_DIV8;
            3'h3:    half_m1 = SMF_HALF_DIV16;
            3'h4:    half_m1 = SMF_HALF_DIV32;
            default: half_m1 = SMF_HALF_DIV64;
        endcase
    end

    // a new byte needs room in rx as well, so a slow reader stalls the link
    assign start = cfg_ff.master_on && (state_ff == SMF_IDLE) && tx_out_valid && rx_in_ready;
    assign tick  = cfg_ff.master_on && (state_ff == SMF_SHIFT) && (div_cnt_ff == half_m1);
    assign done  = tick && (edge_idx_ff == SMF_LAST_EDGE);
    assign lead  = !edge_idx_ff[0];
    // phase picks which edge shifts and which samples
    assign shift_evt  = tick && (cfg_ff.sample_edge_sel ? lead : (!lead && !done));
    assign sample_evt = tick && (cfg_ff.sample_edge_sel ? !lead : lead);
    // lsb first fills from the top, msb first from the bottom
    assign nxt_rx_sh = !sample_evt ? rx_sh_ff :
                       cfg_ff.bit_order_sel ? {din_s2_ff, rx_sh_ff[SMF_DATA_W-1:1]} :
                       {rx_sh_ff[SMF_DATA_W-2:0], din_s2_ff};

    // byte state; disabled means everything holds where it is
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            state_ff <= SMF_IDLE;
        end else if (start) begin
            state_ff <= SMF_SHIFT;
        end else if (done) begin
            state_ff <= SMF_IDLE;
        end
    end

    // divider and edge counter
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            div_cnt_ff  <= '0;
            edge_idx_ff <= '0;
        end else if (cfg_ff.master_on) begin
            if (state_ff == SMF_IDLE || tick) begin
                div_cnt_ff <= '0;
            end else begin
                div_cnt_ff <= 5'(div_cnt_ff + 1'b1);
            end
            if (start) begin
                edge_idx_ff <= '0;
            end else if (tick) begin
                edge_idx_ff <= 4'(edge_idx_ff + 1'b1);
            end
        end
    end

    // serial clock; sixteen toggles bring it back to idle
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            sck_ff <= 1'b0;
        end else if (state_ff == SMF_IDLE) begin
            sck_ff <= 1'b0;
        end else if (tick) begin
            sck_ff <= !sck_ff;
        end
    end
    assign SER_CLK_OUT_O = sck_ff ^ cfg_ff.sck_idle_level;

    // transmit shifter and data-out register
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            tx_sh_ff <= '0;
            mosi_ff  <= 1'b0;
        end else if (start) begin
            tx_sh_ff <= tx_out_data;
            if (!cfg_ff.sample_edge_sel) begin
                mosi_ff <= first_bit(tx_out_data, cfg_ff.bit_order_sel);
            end
        end else if (shift_evt) begin
            tx_sh_ff <= shift_out(tx_sh_ff, cfg_ff.bit_order_sel);
            if (cfg_ff.sample_edge_sel) begin
                mosi_ff <= first_bit(tx_sh_ff, cfg_ff.bit_order_sel);
            end else begin
                mosi_ff <= first_bit(shift_out(tx_sh_ff, cfg_ff.bit_order_sel), cfg_ff.bit_order_sel);
            end
        end
    end
    assign SER_DATA_OUT_O = mosi_ff;

    // receive shifter
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            rx_sh_ff <= '0;
        end else begin
            rx_sh_ff <= nxt_rx_sh;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    localparam logic [6:0] SMF_BYTE_CYC_DIV8 = 7'h3f; // sixteen half periods of four clocks, less one
    logic [6:0]            byte_cyc_ff;
    // byte length in mcu clocks; parks at all ones once config moves, so the check stays quiet then
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I || wr_cfg || !cfg_ff.master_on) begin
            byte_cyc_ff <= '1;
        end else begin
            byte_cyc_ff <= start ? '0 : (byte_cyc_ff == '1) ? byte_cyc_ff : 7'(byte_cyc_ff + 1'b1);
        end
    end

    sequence s_load_div8;
        start && (cfg_ff.sck_divider_sel == 3'h2) && !wr_cfg;
    endsequence

    property p_off_frozen;
        @(posedge CLK_I) disable iff (!RST_B_I)
        !cfg_ff.master_on && !wr_cfg |=> $stable(SER_CLK_OUT_O) && $stable(edge_idx_ff);
    endproperty
    a_off_frozen: assert property (p_off_frozen) else $error("core moved while disabled");
    property p_div8_first_edge;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_load_div8 ##1 (cfg_ff.master_on && !wr_cfg)[*3] ##1 cfg_ff.master_on |-> tick;
    endproperty
    a_div8_first_edge: assert property (p_div8_first_edge) else $error("divide by 8 timing wrong");
    property p_idle_level;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (state_ff == SMF_IDLE) |-> (SER_CLK_OUT_O == cfg_ff.sck_idle_level);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("serial clock not at idle level");

    property p_mode0_msb;
        @(posedge CLK_I) disable iff (!RST_B_I)
        start && !cfg_ff.sample_edge_sel && !cfg_ff.bit_order_sel && !wr_cfg
        |=> SER_DATA_OUT_O == $past(tx_out_data[SMF_DATA_W-1]);
    endproperty
    a_mode0_msb: assert property (p_mode0_msb) else $error("first bit not msb");

    property p_irq;
        @(posedge CLK_I) disable iff (!RST_B_I)
        ##1 IRQ_O == $past(|(flags[3:0] & ~mask_ff[3:0]));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt does not follow masked status");

    property p_flags;
        @(posedge CLK_I) disable iff (!RST_B_I)
        flags.rx_full_flag == (rx_level == 2'h2) && flags.rx_avail_flag == (rx_level != 2'h0)
        && flags.tx_empty_flag == (tx_level == 2'h0) && flags.tx_space_flag == (tx_level != 2'h2);
    endproperty
    a_flags: assert property (p_flags) else $error("status flags disagree with fifo levels");

    property p_push;
        @(posedge CLK_I) disable iff (!RST_B_I)
        wr_data && tx_in_ready && !start |=> tx_level == $past(tx_level) + 2'h1;
    endproperty
    a_push: assert property (p_push) else $error("write did not push tx fifo");

    property p_pop;
        @(posedge CLK_I) disable iff (!RST_B_I)
        rd_data && rx_out_valid && !done |=> rx_level == $past(rx_level) - 2'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("read did not pop rx fifo");
    property p_byte_len;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (state_ff == SMF_SHIFT) && (byte_cyc_ff != '1) && (cfg_ff.sck_divider_sel == 3'h2)
        |-> done == (byte_cyc_ff == SMF_BYTE_CYC_DIV8);
    endproperty
    a_byte_len: assert property (p_byte_len) else $error("byte did not end after 16 half periods");

endmodule : smf_spi_master

// [test/smf_slave_model.sv]
// smf_slave_model: behavioural spi slave on the master's serial pins.
// assumes the bench drives select and mode inputs like a gpio pin would.
`timescale 1ns/100ps

module smf_slave_model (
    // select and mode from the bench
    input  wire logic       sel_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    input  wire logic       lsb_i,
    input  wire logic [7:0] seed_i,
    // serial pins
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    // last byte received
    output logic [7:0]      rx_o
);
    // ---------------------------------------------
    // shift logic
    // ---------------------------------------------
    logic [7:0] shd  = 8'h00;
    logic [7:0] acc  = 8'h00;
    logic       last = 1'b0;
    int         e    = 0;
    int         idx;

    function automatic int pos(input int k);
        return lsb_i ? k : 7 - k;
    endfunction : pos

    // bit slot: phase 1 moves on the leading edge, so it lags one edge
    assign idx = (cpha_i && e > 0) ? (e - 1) / 2 : e / 2;

    // select comes from a gpio, never from the master
    always @(posedge sel_i) begin
        shd = seed_i;
        e   = 0;
    end

    // edges seen while deselected are ignored, so mode changes are safe
    always @(sck_i) begin
        if (sel_i) begin
            if (e[0] == cpha_i) acc[pos(e / 2)] = mosi_i;
            e = e + 1;
            if (e == 16) begin
                rx_o = acc;
                shd  = acc;
                e    = 0;
            end
        end
    end

    // released line shows the inverse of its last bit
    always @(negedge sel_i) last = shd[pos(idx)];
    assign miso_o = sel_i ? shd[pos(idx)] : ~last;
    initial rx_o = 8'h00;
endmodule : smf_slave_model

// [test/tb_spi_master_fifo.sv]
// tb_spi_master_fifo: register-level tests of the spi master via its sfr bus.
// assumes the slave model on the serial pins and a 250 MHz mcu clock.
`timescale 1ns/100ps

module tb_spi_master_fifo;
    import smf_pkg::*;
    // ---------------------------------------------
    // clock, reset and wiring
    // ---------------------------------------------
    logic         clk, rst_b, sck, mosi, miso, irq, sel, cpol, cpha, lsb;
    smf_sfr_req_t req;
    logic [7:0]   rdata, seed, srx, got;
    int           err_total, n_checks, cyc, n;

    smf_spi_master dut_u (.CLK_I(clk), .RST_B_I(rst_b), .SFR_REQ_I(req), .SFR_RDATA_O(rdata),
        .SER_CLK_OUT_O(sck), .SER_DATA_OUT_O(mosi), .SER_DATA_IN_I(miso), .IRQ_O(irq));
    smf_slave_model slave_u (.sel_i(sel), .cpol_i(cpol), .cpha_i(cpha), .lsb_i(lsb), .seed_i(seed),
        .sck_i(sck), .mosi_i(mosi), .miso_o(miso), .rx_o(srx));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ---------------------------------------------
    // bus tasks and checks
    // ---------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        n_checks++;
        if (g !== x) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    // each access ends with an idle edge so the next one never reassigns req in the same step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{a, 1'b1, 1'b0, d};
        @(posedge clk); #1;
        req.wr = 1'b0;
        @(posedge clk); #1;
    endtask : wr
    task automatic rd_raw(input logic [7:0] a);
        req = '{a, 1'b0, 1'b1, 8'h00};
        @(posedge clk); #1;
        req.rd = 1'b0;
        got = rdata;
        @(posedge clk); #1;
    endtask : rd_raw
    task automatic rc(input logic [7:0] a, input logic [7:0] x);
        rd_raw(a);
        chk(got, x);
    endtask : rc
    // poll the flags with rd held high; a flag that never comes counts as a mismatch
    task automatic wait_flag(input int b);
        int i;
        i = 0;
        req = '{SMF_ADDR_FLAGS, 1'b0, 1'b1, 8'h00};
        do begin
            @(posedge clk); #1;
            i++;
        end while (rdata[b] !== 1'b1 && i < 1000);
        req.rd = 1'b0;
        @(posedge clk); #1;
        chk({7'h0, rdata[b]}, 8'h01);
    endtask : wait_flag
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    task automatic toggle_wait;
        logic s;
        s = sck;
        n = 0;
        while (sck === s && n < 99) begin
            @(posedge clk); #1;
            n++;
        end
    endtask : toggle_wait
    // mode is set while deselected so the slave sees no false edge
    task automatic xfer(input logic [7:0] c, input logic [7:0] d);
        {lsb, cpol, cpha} = c[3:1];
        wr(SMF_ADDR_CFG, c);
        chk({7'h0, sck}, {7'h0, c[2]});
        sel = 1'b1;
        wr(SMF_ADDR_DATA, d);
        wait_flag(2);
        rc(SMF_ADDR_DATA, seed);
        chk(srx, d);
        sel = 1'b0;
    endtask : xfer
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // tests need under 10000 cycles; a hang is cut well above that
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            final_report();
        end
    end

    // ---------------------------------------------
    // test sequence
    // ---------------------------------------------
    initial begin
        {req, sel, cpol, cpha, lsb, seed, rst_b} = '0;
        {err_total, n_checks, cyc} = '0;
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        rc(SMF_ADDR_CFG, SMF_CFG_RST);
        chk({7'h0, sck}, 8'h00);
        rc(SMF_ADDR_MASK, 8'h0f);
        rc(SMF_ADDR_FLAGS, 8'h03);
        rc(SMF_ADDR_DATA, 8'h00);
        rc(8'h10, 8'h00);
        wr(SMF_ADDR_FLAGS, 8'hff);
        rc(SMF_ADDR_FLAGS, 8'h03);
        chk({7'h0, irq}, 8'h00);
        wr(SMF_ADDR_MASK, 8'h0d);
        step(2);
        chk({7'h0, irq}, 8'h01);
        // master off: bytes wait in the fifo, third one is refused
        wr(SMF_ADDR_DATA, 8'h3c);
        step(2);
        chk({7'h0, irq}, 8'h00);
        rc(SMF_ADDR_FLAGS, 8'h01);
        wr(SMF_ADDR_DATA, 8'hc3);
        wr(SMF_ADDR_DATA, 8'h77);
        rc(SMF_ADDR_FLAGS, 8'h00);
        step(100);
        chk({7'h0, sck}, 8'h00);
        wr(SMF_ADDR_MASK, 8'h07);
        seed = 8'h5a;
        sel  = 1'b1;
        wr(SMF_ADDR_CFG, 8'h21);
        wait_flag(3);
        rc(SMF_ADDR_FLAGS, 8'h0f);
        step(2);
        chk({7'h0, irq}, 8'h01);
        // rx full holds the next byte back without losing it
        wr(SMF_ADDR_DATA, 8'h99);
        step(100);
        rc(SMF_ADDR_FLAGS, 8'h0d);
        rc(SMF_ADDR_DATA, 8'h5a);
        wait_flag(3);
        rc(SMF_ADDR_DATA, 8'h3c);
        rc(SMF_ADDR_DATA, 8'hc3);
        step(100);
        rc(SMF_ADDR_FLAGS, 8'h03);
        rc(SMF_ADDR_DATA, 8'h00);
        chk(srx, 8'h99);
        sel = 1'b0;
        wr(SMF_ADDR_MASK, 8'h0f);
        // all modes with both bit orders
        for (int m = 0; m < 8; m++) begin
            seed = 8'hb1 ^ 8'(m * 17);
            xfer({4'h2, m[2:0], 1'b1}, 8'h1d + 8'(m));
        end
        // serial clock half period for every divider code
        for (int c = 0; c < 8; c++) begin
            wr(SMF_ADDR_CFG, {1'b0, c[2:0], 4'h1});
            wr(SMF_ADDR_DATA, 8'h00);
            toggle_wait();
            toggle_wait();
            chk(8'(n), (c > 4) ? 8'h20 : 8'h01 << c);
            wait_flag(2);
            rc(SMF_ADDR_FLAGS, 8'h07);
            wait_flag(1);
            rc(SMF_ADDR_FLAGS, 8'h07);
            rd_raw(SMF_ADDR_DATA);
        end
        final_report();
    end
endmodule : tb_spi_master_fifo
